// file: aost_capture_model.sv
`timescale 1ns/1ps
module aost_capture_model (
  // from the block
  input logic clk,
  input logic rst,
  input logic [aost_pkg::SAMPLE_W-1:0] bus_first,
  input logic sync_marker_first_bus,
  input logic sync_marker_out,
  // captured
  output logic [aost_pkg::SAMPLE_W-1:0] marked_word,
  output logic [7:0] marker_count
);
  import aost_pkg::*;
  logic prev_q;
  always @(posedge clk) begin
    prev_q <= sync_marker_out;
    if (rst) begin
      marker_count <= 8'h00;
      marked_word <= 12'h000;
    end else begin
      if (sync_marker_out && !prev_q) marker_count <= marker_count + 8'h01;
      if (sync_marker_first_bus) marked_word <= bus_first;
    end
  end
endmodule : aost_capture_model

// file: aost_check_monitor.sv
`timescale 1ns/1ps
module aost_check_monitor (
  // clock, reset, stream
  input logic clk,
  input logic rst,
  input logic [aost_pkg::SAMPLE_W-1:0] sample_in,
  input logic [aost_pkg::SAMPLE_W-1:0] bus_first,
  input logic [aost_pkg::SAMPLE_W-1:0] bus_second,
  input logic sync_marker_first_bus,
  input logic sync_marker_second_bus,
  input logic sync_marker_out,
  input logic [aost_pkg::OFFSET_W-1:0] offset_trim,
  // register bus
  input logic [aost_pkg::ADDR_W-1:0] s_axi_awaddr,
  input logic [aost_pkg::DATA_W-1:0] s_axi_wdata,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready
);
  import aost_pkg::*;
  logic [1:0] mode_q;
  logic [3:0] settle_q;
  // mode snooped from ctrl writes; assumes address offered with the data
  always_ff @(posedge clk) begin
    if (rst || (s_axi_wvalid && s_axi_wready && s_axi_awaddr == REG_CTRL)) begin
      mode_q <= rst ? 2'h0 : s_axi_wdata[1:0];
      settle_q <= 4'h0;
    end else if (settle_q != 4'hF) begin
      settle_q <= settle_q + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_wait_s;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  marker_out_follow_a: assert property (
    sync_marker_out == (sync_marker_first_bus || sync_marker_second_bus))
    else $error("marker out not beside bus marker");
  reset_values_a: assert property ($fell(rst) |-> offset_trim == OFFSET_DEFAULT
    && bus_first == 12'h000 && bus_second == 12'h000)
    else $error("wrong values after reset");
  write_answer_a: assert property (wr_taken_s |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  b_hold_a: assert property (b_wait_s |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after take");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  single_latency_a: assert property (
    settle_q == 4'hF && mode_q != 2'h1 && mode_q != 2'h2 |->
    bus_first == $past(sample_in, 8) && bus_second == 12'h000)
    else $error("single bus word or latency wrong");
  dual_pairs_a: assert property (
    settle_q == 4'hF && mode_q == 2'h1 && $changed(bus_first) |->
    bus_first == $past(sample_in, 9) && bus_second == $past(sample_in, 10))
    else $error("aligned pair wrong");
endmodule : aost_check_monitor

// file: aost_core.sv
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module aost_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // converter core and sync pin
  input wire logic [aost_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic sync_reset_pos,
  // output buses
  output logic [aost_pkg::SAMPLE_W-1:0] bus_first,
  output logic [aost_pkg::SAMPLE_W-1:0] bus_second,
  output logic sync_marker_first_bus,
  output logic sync_marker_second_bus,
  output logic sync_marker_out,
  output logic data_ready_clock_out,
  // trim controls
  output logic [aost_pkg::OFFSET_W-1:0] offset_trim,
  output logic [aost_pkg::FINE_W-1:0] fine_phase_trim,
  output logic [aost_pkg::COARSE_W-1:0] coarse_phase_trim,
  // axi4-lite write
  input wire logic [aost_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [aost_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [aost_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [aost_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import aost_pkg::*;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] rst_sync;
    logic rst_prev;
    logic [1:0] phase;
    logic [PIPE_DEPTH-1:0][SAMPLE_W:0] pipe;
    logic [SAMPLE_W-1:0] data_a;
    logic [SAMPLE_W-1:0] data_b;
    logic mark_a;
    logic mark_b;
    logic mark_any;
    logic clk_out;
    aost_mode_type mode;
    logic div4;
    logic sync_en;
    logic [OFFSET_W-1:0] offset;
    logic [FINE_W-1:0] fine;
    logic [COARSE_W-1:0] coarse;
    logic [15:0] sync_count;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
  } aost_state_type;

  aost_state_type q;
  aost_state_type d;

  function automatic aost_dec_type decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      REG_CTRL: decode = AOST_DEC_CTRL;
      REG_OFFSET: decode = AOST_DEC_OFFSET;
      REG_FINE: decode = AOST_DEC_FINE;
      REG_COARSE: decode = AOST_DEC_COARSE;
      REG_STATUS: decode = AOST_DEC_STATUS;
      default: decode = AOST_DEC_NONE;
    endcase
  endfunction : decode

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction : merge

  logic sync_edge;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] wr_val;
  logic [OFFSET_W:0] off_dist;
  logic off_out_of_range;

  assign sync_edge = q.rst_sync[SYNC_STAGES-1] & ~q.rst_prev & q.sync_en;
  // distance from default; range flag only advises, the trim is not clamped
  assign off_dist = (q.offset >= OFFSET_DEFAULT) ?
                    {1'b0, q.offset - OFFSET_DEFAULT} : {1'b0, OFFSET_DEFAULT - q.offset};
  assign off_out_of_range = off_dist > (OFFSET_W + 1)'(OFFSET_REC_LSB);

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_MODE_LSB +: 2] = q.mode;
    ctrl_word[CTRL_DIV4_BIT] = q.div4;
    ctrl_word[CTRL_SYNC_EN_BIT] = q.sync_en;
    status_word = '0;
    status_word[STAT_PHASE_LSB +: 2] = q.phase;
    status_word[STAT_RANGE_BIT] = off_out_of_range;
    status_word[STAT_COUNT_LSB +: 16] = q.sync_count;
  end

  always_comb begin
    // merge scratch has one driver, here
    wr_val = '0;
    d = q;
    // two-flop synchroniser; first stage feeds only the second
    d.rst_sync = {q.rst_sync[SYNC_STAGES-2:0], sync_reset_pos};
    d.rst_prev = q.rst_sync[SYNC_STAGES-1];

    // divided clock runs free from any phase; a capture forces phase zero
    d.phase = q.phase + 2'h1;
    if (sync_edge) begin
      d.phase = 2'h0;
      d.sync_count = q.sync_count + 16'h0001;
    end
    d.clk_out = q.div4 ? q.phase[1] : q.phase[0];

    // marker enters beside the sample present at capture
    d.pipe[0] = {sync_edge, sample_in};
    for (int i = 1; i < PIPE_DEPTH; i++) begin
      d.pipe[i] = q.pipe[i-1];
    end

    unique case (q.mode)
      AOST_DUAL_ALIGNED: begin
        // both buses turn together, second bus one sample older
        if (q.phase[0]) begin
          {d.mark_a, d.data_a} = q.pipe[LAT_DUAL_A-1];
          {d.mark_b, d.data_b} = q.pipe[LAT_DUAL_B-1];
        end
      end
      AOST_DUAL_STAGGERED: begin
        // buses turn on alternate cycles
        if (q.phase[0]) begin
          {d.mark_b, d.data_b} = q.pipe[LAT_DUAL_A-1];
        end else begin
          {d.mark_a, d.data_a} = q.pipe[LAT_DUAL_A-1];
        end
      end
      default: begin
        {d.mark_a, d.data_a} = q.pipe[LAT_SINGLE-1];
        d.mark_b = 1'b0;
        d.data_b = '0;
      end
    endcase
    d.mark_any = d.mark_a | d.mark_b;

    // write channel: address and data taken in either order
    if (q.awready && s_axi_awvalid) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
      d.awready = 1'b0;
    end
    if (q.wready && s_axi_wvalid) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
      d.wready = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      unique case (decode(q.aw_addr))
        AOST_DEC_CTRL: begin
          wr_val = merge(ctrl_word, q.w_data, q.w_strb);
          // the unused mode code falls back to single bus
          d.mode = (wr_val[CTRL_MODE_LSB +: 2] == 2'h3) ? AOST_SINGLE :
                   aost_mode_type'(wr_val[CTRL_MODE_LSB +: 2]);
          d.div4 = wr_val[CTRL_DIV4_BIT];
          d.sync_en = wr_val[CTRL_SYNC_EN_BIT];
        end
        AOST_DEC_OFFSET: begin
          wr_val = merge({{(DATA_W-OFFSET_W){1'b0}}, q.offset}, q.w_data, q.w_strb);
          d.offset = wr_val[OFFSET_W-1:0];
        end
        AOST_DEC_FINE: begin
          wr_val = merge({{(DATA_W-FINE_W){1'b0}}, q.fine}, q.w_data, q.w_strb);
          d.fine = wr_val[FINE_W-1:0];
        end
        AOST_DEC_COARSE: begin
          wr_val = merge({{(DATA_W-COARSE_W){1'b0}}, q.coarse}, q.w_data, q.w_strb);
          d.coarse = wr_val[COARSE_W-1:0];
        end
        AOST_DEC_STATUS: d.bresp = RESP_OKAY;
        AOST_DEC_NONE: d.bresp = RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // read channel
    if (q.arready && s_axi_arvalid) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      unique case (decode(s_axi_araddr))
        AOST_DEC_CTRL: d.rdata = ctrl_word;
        AOST_DEC_OFFSET: d.rdata = {{(DATA_W-OFFSET_W){1'b0}}, q.offset};
        AOST_DEC_FINE: d.rdata = {{(DATA_W-FINE_W){1'b0}}, q.fine};
        AOST_DEC_COARSE: d.rdata = {{(DATA_W-COARSE_W){1'b0}}, q.coarse};
        AOST_DEC_STATUS: d.rdata = status_word;
        AOST_DEC_NONE: begin
          d.rdata = '0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    if (rst) begin
      d = '0;
      d.mode = AOST_SINGLE;
      d.sync_en = 1'b1;
      d.offset = OFFSET_DEFAULT;
      d.fine = FINE_DEFAULT;
      d.coarse = COARSE_DEFAULT;
      d.awready = 1'b1;
      d.wready = 1'b1;
      d.arready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign bus_first = q.data_a;
  assign bus_second = q.data_b;
  assign sync_marker_first_bus = q.mark_a;
  assign sync_marker_second_bus = q.mark_b;
  assign sync_marker_out = q.mark_any;
  assign data_ready_clock_out = q.clk_out;
  assign offset_trim = q.offset;
  assign fine_phase_trim = q.fine;
  assign coarse_phase_trim = q.coarse;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;

endmodule : aost_core

// file: aost_pkg.sv
package aost_pkg;

  // sample path
  localparam int SAMPLE_W = 12;
  localparam int LAT_SINGLE = 7;
  localparam int LAT_DUAL_A = 8;
  localparam int LAT_DUAL_B = 9;
  localparam int PIPE_DEPTH = 9;
  localparam int SYNC_STAGES = 2;

  // trim widths and nominal step sizes
  localparam int OFFSET_W = 9;
  localparam int FINE_W = 6;
  localparam int COARSE_W = 5;
  localparam int OFFSET_LSB_UV = 120;
  localparam int OFFSET_REC_MV = 8;
  localparam int OFFSET_REC_LSB = (OFFSET_REC_MV * 1000) / OFFSET_LSB_UV;
  localparam int FINE_STEP_FS = 116;
  localparam int COARSE_STEP_FS = 2400;
  localparam logic [OFFSET_W-1:0] OFFSET_DEFAULT = 9'h100;
  localparam logic [FINE_W-1:0] FINE_DEFAULT = 6'h00;
  localparam logic [COARSE_W-1:0] COARSE_DEFAULT = 5'h00;

  // axi4-lite
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FINE = 8'h08;
  localparam logic [ADDR_W-1:0] REG_COARSE = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DIV4_BIT = 2;
  localparam int CTRL_SYNC_EN_BIT = 3;
  // status fields
  localparam int STAT_PHASE_LSB = 0;
  localparam int STAT_RANGE_BIT = 2;
  localparam int STAT_COUNT_LSB = 16;

  typedef enum logic [1:0] {
    AOST_SINGLE,
    AOST_DUAL_ALIGNED,
    AOST_DUAL_STAGGERED
  } aost_mode_type;

  typedef enum logic [2:0] {
    AOST_DEC_CTRL,
    AOST_DEC_OFFSET,
    AOST_DEC_FINE,
    AOST_DEC_COARSE,
    AOST_DEC_STATUS,
    AOST_DEC_NONE
  } aost_dec_type;

endpackage : aost_pkg

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import aost_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [SAMPLE_W-1:0] sample_in = 12'h000;
  logic sync_reset_pos = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [SAMPLE_W-1:0] bus_first, bus_second, marked_word;
  logic sync_marker_first_bus, sync_marker_second_bus, sync_marker_out;
  logic data_ready_clock_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, prev;
  logic [OFFSET_W-1:0] offset_trim;
  logic [FINE_W-1:0] fine_phase_trim;
  logic [COARSE_W-1:0] coarse_phase_trim;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [DATA_W-1:0] s_axi_rdata, rd;
  logic [7:0] marker_count;
  logic [SAMPLE_W-1:0] mark_exp;
  logic [DATA_W-1:0] cfg [6] = '{32'h0000_0008, 32'h0000_000B, 32'h0000_0009,
    32'h0000_000A, 32'h0000_000D, 32'h0000_000E};
  int n_errors = 0;
  int total_checks = 0;
  int i, k, tgl;
  aost_core i_dut (.*);
  aost_capture_model i_cap (.*);
  always #10 clk = ~clk;
  always @(posedge clk) sample_in <= sample_in + 12'h001;
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  task automatic reg_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
      input logic [1:0] er);
    axi_read(a);
    check(rd, e);
    check(32'(rsp), 32'(er));
  endtask : reg_chk
  task automatic pulse_sync();
    repeat (3) @(posedge clk);
    sync_reset_pos <= 1'b1;
    @(posedge clk);
    sync_reset_pos <= 1'b0;
  endtask : pulse_sync
  task automatic complete_run();
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  initial begin
    #100us;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    reg_chk(REG_CTRL, 32'h0000_0008, RESP_OKAY);
    reg_chk(REG_OFFSET, 32'h0000_0100, RESP_OKAY);
    reg_chk(REG_FINE, 32'h0000_0000, RESP_OKAY);
    reg_chk(REG_COARSE, 32'h0000_0000, RESP_OKAY);
    reg_chk(8'h20, 32'h0000_0000, RESP_SLVERR);
    axi_write(8'h40, 32'hFFFF_FFFF);
    check(32'(rsp), 32'(RESP_SLVERR));
    axi_write(REG_FINE, 32'hFFFF_FFFF);
    check(fine_phase_trim, 32'h0000_003F);
    axi_write(REG_COARSE, 32'hFFFF_FFFF);
    check(coarse_phase_trim, 32'h0000_001F);
    axi_write(REG_OFFSET, 32'h0000_0142);
    axi_read(REG_STATUS);
    check(rd & 32'hFFFF_FFFC, 32'h0000_0000);
    check(32'(rsp), 32'(RESP_OKAY));
    axi_write(REG_OFFSET, 32'hFFFF_FF43);
    check(offset_trim, 32'h0000_0143);
    axi_read(REG_STATUS);
    check(rd & 32'h0000_0004, 32'h0000_0004);
    // single, mode three as single, then the four dual arrangements
    for (i = 0; i < 6; i++) begin
      axi_write(REG_CTRL, cfg[i]);
      repeat (16) @(posedge clk);
      @(negedge clk);
      prev = data_ready_clock_out;
      tgl = 0;
      for (k = 0; k < 8; k++) begin
        @(negedge clk);
        if (data_ready_clock_out !== prev) tgl++;
        prev = data_ready_clock_out;
        if (i < 2) begin
          check(bus_first, 12'(sample_in - 12'h008));
          check(bus_second, 32'h0000_0000);
        end else begin
          check(32'(bus_first[0] ^ bus_second[0]), 32'h0000_0001);
        end
      end
      if (i > 1) check(32'(tgl), (i < 4) ? 32'h0000_0008 : 32'h0000_0004);
    end
    axi_write(REG_CTRL, 32'h0000_0008);
    repeat (16) @(posedge clk);
    mark_exp = 12'(sample_in + 12'h003);
    sync_reset_pos <= 1'b1;
    @(posedge clk);
    sync_reset_pos <= 1'b0;
    repeat (16) @(posedge clk);
    check(marker_count, 32'h0000_0001);
    check(marked_word, mark_exp);
    sync_reset_pos <= 1'b1;
    repeat (12) @(posedge clk);
    sync_reset_pos <= 1'b0;
    for (i = 0; i < 3; i++) pulse_sync();
    repeat (16) @(posedge clk);
    check(marker_count, 32'h0000_0005);
    axi_read(REG_STATUS);
    check(32'(rd[31:16]), 32'h0000_0005);
    axi_write(REG_CTRL, 32'h0000_0000);
    pulse_sync();
    repeat (16) @(posedge clk);
    check(marker_count, 32'h0000_0005);
    complete_run();
  end
endmodule : tb
bind aost_core aost_check_monitor i_mon (.*);
